// ===== src/dscsl_pkg.sv
// Purpose: Shared constants and types of the synthesizer output path.
// Assumes: One sample clock drives every register.
// Notes:   Two's complement samples throughout.
package dscsl_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int FTW_W    = 48;
    localparam int DAC_W    = 14;
    localparam int PH_W     = 12;
    localparam int POFF_W   = 9;
    localparam int AMP_W    = 8;
    localparam int HARM_W   = 4;
    localparam int PDIV_W   = 4;
    localparam int CANC_W   = 6;
    localparam int ADDR_W   = 16;
    localparam int REG_W    = 8;
    localparam int SIN_W    = DAC_W;
    localparam int PROD_W   = SIN_W + AMP_W + 1;

    // ------------------------------------------------------------------
    // Cancellation channel constants
    // ------------------------------------------------------------------
    localparam logic [HARM_W-1:0] HARM_MIN   = 4'h2;
    localparam logic [HARM_W-1:0] HARM_MAX   = 4'hF;
    localparam int                CANC_SHIFT = 18;
    localparam int                N_CANC     = 2;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_DBL_CFG_A = 16'h0010;
    localparam logic [ADDR_W-1:0] OFS_DBL_CFG_B = 16'h0200;
    localparam logic [REG_W-1:0]  RST_DBL_CFG   = 8'h00;
    localparam int                DBL_SEL_BIT   = 0;
    localparam int                DBL_PWR_BIT   = 0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [HARM_W-1:0] harm;
        logic [POFF_W-1:0] phase_ofs;
        logic [AMP_W-1:0]  amp;
        logic              gain;
    } dscsl_canc_cfg_s;

    typedef struct packed {
        logic             en;
        logic [FTW_W-1:0] k_slew;
    } dscsl_slew_cfg_s;

    // Parabolic sine of a 12-bit phase, peak just under 2^13
    function automatic logic signed [SIN_W-1:0] dscsl_sin(input logic [PH_W-1:0] ph);
        logic [PH_W-2:0] x;
        logic [21:0]     prod;
        logic [12:0]     mag;
        x    = ph[PH_W-2:0];
        prod = 22'(x) * 22'(11'h7FF - x);
        mag  = prod[19:7];
        return ph[PH_W-1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction

endpackage

// ===== src/dscsl_canc_core.sv
// Purpose: One harmonic cancellation synthesizer core.
// Assumes: Tuning word comes from the main core's interpolated word.
// Notes:   Harmonic settings below two disable the channel.
module dscsl_canc_core
    import dscsl_pkg::*;
(
    input  wire logic                             clk_sys_i,
    input  wire logic                             sys_rst_i,
    input  wire logic                             adv_i,
    input  wire logic [dscsl_pkg::FTW_W-1:0]      ftw_i,
    input  wire dscsl_pkg::dscsl_canc_cfg_s       cfg_i,
    output logic signed [dscsl_pkg::CANC_W-1:0]   samp_o
);
    import dscsl_pkg::*;

    // ------------------------------------------------------------------
    // Phase accumulator
    // ------------------------------------------------------------------
    logic [FTW_W-1:0]          acc_q;
    logic [FTW_W-1:0]          acc_d;
    logic [FTW_W+HARM_W-1:0]   inc_full;
    logic                      active;

    assign active   = (cfg_i.harm >= HARM_MIN) && (cfg_i.harm <= HARM_MAX);
    assign inc_full = ftw_i * cfg_i.harm;

    always_comb begin
        acc_d = acc_q;
        if (!active) begin
            acc_d = '0;
        end else if (adv_i) begin
            acc_d = acc_q + inc_full[FTW_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // ------------------------------------------------------------------
    // Offset, lookup, scaling
    // ------------------------------------------------------------------
    logic [PH_W-1:0]          ph;
    logic signed [SIN_W-1:0]  sin_v;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] scaled;

    // Offset spans the full circle, so +-pi lands on the top bit
    assign ph     = acc_q[FTW_W-1 -: PH_W] + {cfg_i.phase_ofs, 3'h0};
    assign sin_v  = dscsl_sin(ph);
    assign prod   = sin_v * $signed({1'b0, cfg_i.amp});
    // Shift keeps full scale near the four lowest converter bits
    assign scaled = (prod >>> CANC_SHIFT) <<< cfg_i.gain;

    assign samp_o = active ? scaled[CANC_W-1:0] : '0;

endmodule

// ===== src/dscsl_skid2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock.
// Notes:   Output data comes straight from the head register.
module dscsl_skid2 #(
    parameter int W = 14
) (
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    logic [W-1:0] head_q, head_d, tail_q, tail_d;
    logic         hv_q, hv_d, tv_q, tv_d;
    logic         push, pop;

    // Ready only while the tail slot is free, so a stall fills both
    assign in_ready_o  = !tv_q;
    assign push        = in_valid_i && !tv_q;
    assign pop         = hv_q && out_ready_i;
    assign out_valid_o = hv_q;
    assign out_data_o  = head_q;

    always_comb begin
        head_d = head_q;
        tail_d = tail_q;
        hv_d   = hv_q;
        tv_d   = tv_q;
        if (pop) begin
            head_d = tail_q;
            hv_d   = tv_q;
            tv_d   = 1'b0;
        end
        if (push) begin
            if (!hv_d) begin
                head_d = in_data_i;
                hv_d   = 1'b1;
            end else begin
                tail_d = in_data_i;
                tv_d   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            head_q <= '0;
            tail_q <= '0;
            hv_q   <= 1'b0;
            tv_q   <= 1'b0;
        end else begin
            head_q <= head_d;
            tail_q <= tail_d;
            hv_q   <= hv_d;
            tv_q   <= tv_d;
        end
    end

endmodule

// ===== src/dscsl_top.sv
// Purpose: Synthesizer output path: slew limiter, spur cancellation, output controls.
// Assumes: Loop filter, interpolation filter and converter share clk_sys_i.
// Notes:   Interpolation filter sits outside, between ftw_o and dds_ftw_i.
module dscsl_top
    import dscsl_pkg::*;
(
    input  wire logic                          clk_sys_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          lf_valid_i,
    input  wire logic [dscsl_pkg::FTW_W-1:0]   lf_ftw_i,
    input  wire dscsl_pkg::dscsl_slew_cfg_s    slew_cfg_i,
    output logic [dscsl_pkg::FTW_W-1:0]        ftw_o,
    output logic                               ftw_valid_o,
    input  wire logic [dscsl_pkg::FTW_W-1:0]   dds_ftw_i,
    input  wire dscsl_pkg::dscsl_canc_cfg_s    canc0_cfg_i,
    input  wire dscsl_pkg::dscsl_canc_cfg_s    canc1_cfg_i,
    output logic [dscsl_pkg::DAC_W-1:0]        dac_data_o,
    output logic                               dac_valid_o,
    input  wire logic                          dac_ready_i,
    input  wire logic                          out_pd_i,
    input  wire logic                          cmos_src_i,
    output logic                               out_pd_o,
    output logic                               cmos_src_o,
    output logic                               dbl_en_o,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    input  wire logic [dscsl_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [dscsl_pkg::REG_W-1:0]   reg_wdata_i,
    output logic [dscsl_pkg::REG_W-1:0]        reg_rdata_o
);
    import dscsl_pkg::*;

    // ------------------------------------------------------------------
    // Frequency slew limiter
    // ------------------------------------------------------------------
    logic [FTW_W-1:0]        fw_q, fw_d;
    logic                    fv_q, fv_d;
    logic signed [FTW_W:0]   diff;
    logic signed [FTW_W:0]   k_pos;

    // Word differences wrap, so compare in one extra bit of sign
    assign diff  = $signed({1'b0, lf_ftw_i}) - $signed({1'b0, fw_q});
    assign k_pos = $signed({1'b0, slew_cfg_i.k_slew});

    always_comb begin
        fw_d = fw_q;
        fv_d = lf_valid_i;
        if (lf_valid_i) begin
            if (!slew_cfg_i.en) begin
                fw_d = lf_ftw_i;
            end else if (diff > k_pos) begin
                fw_d = fw_q + slew_cfg_i.k_slew;
            end else if (diff < -k_pos) begin
                fw_d = fw_q - slew_cfg_i.k_slew;
            end else begin
                fw_d = lf_ftw_i;
            end
        end
    end

    // Enable lives in slew_cfg_i; its source register resets to zero
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fw_q <= '0;
            fv_q <= 1'b0;
        end else begin
            fw_q <= fw_d;
            fv_q <= fv_d;
        end
    end

    assign ftw_o       = fw_q;
    assign ftw_valid_o = fv_q;

    // ------------------------------------------------------------------
    // Main synthesizer core
    // ------------------------------------------------------------------
    logic [FTW_W-1:0]        acc_q, acc_d;
    logic                    adv;
    logic                    buf_ready;
    logic signed [SIN_W-1:0] main_s;

    // Stalls with the buffer so no sample is lost or skipped
    assign adv    = buf_ready;
    assign main_s = dscsl_sin(acc_q[FTW_W-1 -: PH_W]);

    always_comb begin
        acc_d = acc_q;
        if (adv) begin
            acc_d = acc_q + dds_ftw_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // ------------------------------------------------------------------
    // Cancellation cores
    // ------------------------------------------------------------------
    logic signed [CANC_W-1:0] canc_s [N_CANC];

    dscsl_canc_core u_canc0 (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .adv_i     (adv),
        .ftw_i     (dds_ftw_i),
        .cfg_i     (canc0_cfg_i),
        .samp_o    (canc_s[0])
    );

    dscsl_canc_core u_canc1 (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .adv_i     (adv),
        .ftw_i     (dds_ftw_i),
        .cfg_i     (canc1_cfg_i),
        .samp_o    (canc_s[1])
    );

    // ------------------------------------------------------------------
    // Summation and saturation
    // ------------------------------------------------------------------
    logic signed [DAC_W+1:0] sum;
    logic [DAC_W-1:0]        sat;

    localparam logic signed [DAC_W+1:0] SAT_HI = 16'sh1FFF;
    localparam logic signed [DAC_W+1:0] SAT_LO = -16'sh2000;

    assign sum = (DAC_W+2)'(main_s) + (DAC_W+2)'(canc_s[0])
               + (DAC_W+2)'(canc_s[1]);

    // Main peak sits below full scale, so clipping is rare
    always_comb begin
        if (sum > SAT_HI) begin
            sat = SAT_HI[DAC_W-1:0];
        end else if (sum < SAT_LO) begin
            sat = SAT_LO[DAC_W-1:0];
        end else begin
            sat = sum[DAC_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Converter buffer
    // ------------------------------------------------------------------
    dscsl_skid2 #(
        .W (DAC_W)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (1'b1),
        .in_ready_o  (buf_ready),
        .in_data_i   (sat),
        .out_valid_o (dac_valid_o),
        .out_ready_i (dac_ready_i),
        .out_data_o  (dac_data_o)
    );

    // ------------------------------------------------------------------
    // Output controls and doubler registers
    // ------------------------------------------------------------------
    logic [REG_W-1:0] cfg_a_q, cfg_a_d, cfg_b_q, cfg_b_d, rd_q, rd_d;
    logic             pd_q, pd_d, src_q, src_d, dbl_q, dbl_d;

    always_comb begin
        cfg_a_d = cfg_a_q;
        cfg_b_d = cfg_b_q;
        rd_d    = rd_q;
        if (reg_wr_i && reg_addr_i == OFS_DBL_CFG_A) begin
            cfg_a_d = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == OFS_DBL_CFG_B) begin
            cfg_b_d = reg_wdata_i;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_DBL_CFG_A: rd_d = cfg_a_q;
                OFS_DBL_CFG_B: rd_d = cfg_b_q;
                default:       rd_d = '0;
            endcase
        end
        // Multiplier needs both its select and its power-up
        dbl_d = cfg_a_q[DBL_SEL_BIT] & cfg_b_q[DBL_PWR_BIT];
        pd_d  = out_pd_i;
        // Returned-signal source is only valid up to 50 MHz output
        src_d = cmos_src_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cfg_a_q <= RST_DBL_CFG;
            cfg_b_q <= RST_DBL_CFG;
            rd_q    <= '0;
            dbl_q   <= 1'b0;
            pd_q    <= 1'b0;
            src_q   <= 1'b0;
        end else begin
            cfg_a_q <= cfg_a_d;
            cfg_b_q <= cfg_b_d;
            rd_q    <= rd_d;
            dbl_q   <= dbl_d;
            pd_q    <= pd_d;
            src_q   <= src_d;
        end
    end

    assign reg_rdata_o = rd_q;
    assign dbl_en_o    = dbl_q;
    assign out_pd_o    = pd_q;
    assign cmos_src_o  = src_q;

endmodule

// ===== testbench/dscsl_top_monitor.sv
// Purpose: Port checker for the synthesizer output path.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every dscsl_top instance.
module dscsl_top_chk
    import dscsl_pkg::*;
(
    input wire logic                         clk_sys_i,
    input wire logic                         sys_rst_i,
    input wire logic                         lf_valid_i,
    input wire logic [dscsl_pkg::FTW_W-1:0]  lf_ftw_i,
    input wire dscsl_pkg::dscsl_slew_cfg_s   slew_cfg_i,
    input wire logic [dscsl_pkg::FTW_W-1:0]  ftw_o,
    input wire logic                         ftw_valid_o,
    input wire logic [dscsl_pkg::DAC_W-1:0]  dac_data_o,
    input wire logic                         dac_valid_o,
    input wire logic                         dac_ready_i,
    input wire logic                         out_pd_i,
    input wire logic                         cmos_src_i,
    input wire logic                         out_pd_o,
    input wire logic                         cmos_src_o,
    input wire logic                         dbl_en_o,
    input wire logic                         reg_wr_i,
    input wire logic                         reg_rd_i,
    input wire logic [dscsl_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [dscsl_pkg::REG_W-1:0]  reg_wdata_i,
    input wire logic [dscsl_pkg::REG_W-1:0]  reg_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // Unsigned move toward target, never wrapping
    function automatic logic [FTW_W-1:0] step(input logic [FTW_W-1:0] c, t, k);
        if (t >= c) return (t - c > k) ? c + k : t;
        return (c - t > k) ? c - k : t;
    endfunction

    property p_vld_on; lf_valid_i |=> ftw_valid_o; endproperty
    a_vld_on: assert property (p_vld_on) else $error("limited word valid missing");
    property p_vld_off; !lf_valid_i |=> !ftw_valid_o && $stable(ftw_o); endproperty
    a_vld_off: assert property (p_vld_off) else $error("word moved without update");
    property p_pass; lf_valid_i && !slew_cfg_i.en |=> ftw_o == $past(lf_ftw_i); endproperty
    a_pass: assert property (p_pass) else $error("disabled limiter altered word");
    property p_clamp;
        lf_valid_i && slew_cfg_i.en |=>
            ftw_o == step($past(ftw_o), $past(lf_ftw_i), $past(slew_cfg_i.k_slew));
    endproperty
    a_clamp: assert property (p_clamp) else $error("slew clamp wrong");
    property p_hold; dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_data_o); endproperty
    a_hold: assert property (p_hold) else $error("converter word lost in stall");
    property p_pd; 1'b1 |=> out_pd_o == $past(out_pd_i); endproperty
    a_pd: assert property (p_pd) else $error("power-down copy wrong");
    property p_src; 1'b1 |-> ##1 cmos_src_o == $past(cmos_src_i); endproperty
    a_src: assert property (p_src) else $error("cmos source copy wrong");
    property p_dbl_off;
        reg_wr_i && reg_addr_i == OFS_DBL_CFG_B && !reg_wdata_i[DBL_PWR_BIT] |-> ##2 !dbl_en_o;
    endproperty
    a_dbl_off: assert property (p_dbl_off) else $error("doubler on while powered off");
    property p_unmapped;
        reg_rd_i && reg_addr_i != OFS_DBL_CFG_A && reg_addr_i != OFS_DBL_CFG_B
            |-> ##1 reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind dscsl_top dscsl_top_chk i_chk (.clk_sys_i, .sys_rst_i, .lf_valid_i, .lf_ftw_i,
    .slew_cfg_i, .ftw_o, .ftw_valid_o, .dac_data_o, .dac_valid_o, .dac_ready_i, .out_pd_i,
    .cmos_src_i, .out_pd_o, .cmos_src_o, .dbl_en_o, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o);

// ===== testbench/dscsl_dac_model.sv
// Purpose: Converter model taking output words.
// Assumes: Ready changes on the falling edge only.
// Notes:   Stall input lets the bench back-pressure the stream.
module dscsl_dac_model
    import dscsl_pkg::*;
(
    input  wire logic                        clk_sys_i,
    input  wire logic                        stall_i,
    input  wire logic                        dac_valid_i,
    input  wire logic [dscsl_pkg::DAC_W-1:0] dac_data_i,
    output logic                             dac_ready_o,
    output logic [dscsl_pkg::DAC_W-1:0]      last_o,
    output int                               taken_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial dac_ready_o = 1'b0;
    initial taken_o = 0;
    initial last_o = 14'h0000;
    always @(negedge clk_sys_i) dac_ready_o <= !stall_i;
    // Word taken only on a valid-ready edge
    always @(posedge clk_sys_i) begin
        if (dac_valid_i && dac_ready_o) begin
            last_o <= dac_data_i;
            taken_o <= taken_o + 1;
        end
    end
endmodule

// ===== testbench/test_dscsl_top.sv
// Purpose: Self-checking bench of the synthesizer output path.
// Assumes: Main tuning word zero, or half a circle, so the main sine stays zero.
// Notes:   Cancellation words are then the whole converter value.
module test_dscsl_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dscsl_pkg::*;
    localparam logic [FTW_W-1:0] W0 = 48'h1000_0000_0000;
    logic clk_sys_i = 0, sys_rst_i = 1, lf_valid_i = 0, out_pd_i = 0, cmos_src_i = 0;
    logic reg_wr_i = 0, reg_rd_i = 0, stall = 0;
    logic ftw_valid_o, dac_valid_o, dac_ready_i, out_pd_o, cmos_src_o, dbl_en_o;
    logic [FTW_W-1:0] lf_ftw_i = '0, dds_ftw_i = '0, ftw_o, held;
    dscsl_slew_cfg_s slew_cfg_i = '0;
    dscsl_canc_cfg_s canc0_cfg_i = '0, canc1_cfg_i = '0;
    logic [DAC_W-1:0] dac_data_o, dac_last;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic [REG_W-1:0] reg_wdata_i = '0, reg_rdata_o;
    int mismatches = 0, compares = 0, taken, n;

    initial forever #25 clk_sys_i = ~clk_sys_i;

    dscsl_top i_dut (.clk_sys_i, .sys_rst_i, .lf_valid_i, .lf_ftw_i, .slew_cfg_i, .ftw_o,
        .ftw_valid_o, .dds_ftw_i, .canc0_cfg_i, .canc1_cfg_i, .dac_data_o,
        .dac_valid_o, .dac_ready_i, .out_pd_i, .cmos_src_i, .out_pd_o, .cmos_src_o,
        .dbl_en_o, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o);
    dscsl_dac_model i_dac (.clk_sys_i, .stall_i(stall), .dac_valid_i(dac_valid_o),
        .dac_data_i(dac_data_o), .dac_ready_o(dac_ready_i), .last_o(dac_last), .taken_o(taken));

    task automatic final_report;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [FTW_W-1:0] exp, got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(negedge clk_sys_i);
        reg_wr_i = 1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 0;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
        @(negedge clk_sys_i);
        reg_rd_i = 1;
        reg_addr_i = a;
        @(negedge clk_sys_i);
        reg_rd_i = 0;
        check("reg_rdata_o", 48'(exp), 48'(reg_rdata_o));
    endtask

    // Valid stays high between calls, so updates run back to back
    task automatic upd(input logic en, input logic [FTW_W-1:0] k, w, exp);
        @(negedge clk_sys_i);
        lf_valid_i = 1;
        lf_ftw_i = w;
        slew_cfg_i = '{en: en, k_slew: k};
        @(posedge clk_sys_i);
        #1;
        check("ftw_o", exp, ftw_o);
        check("ftw_valid_o", 48'h1, 48'(ftw_valid_o));
    endtask

    // Parabolic sine of the offset, scaled by amplitude, then gain shift
    function automatic int canc(input int ofs, amp, gain);
        int x;
        int m;
        x = (ofs * 8) % 2048;
        m = ((x * (2047 - x)) >> 7) % 8192;
        if (ofs >= 256) m = -m;
        return ((m * amp) >>> 18) <<< gain;
    endfunction

    initial begin
        repeat (12) @(negedge clk_sys_i);
        sys_rst_i = 0;
        n = 0;
        while (dac_valid_o !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 20) begin
            mismatches++;
            final_report();
        end
        reg_rd(OFS_DBL_CFG_A, RST_DBL_CFG);
        reg_rd(OFS_DBL_CFG_B, RST_DBL_CFG);
        reg_wr(OFS_DBL_CFG_A, 8'hA5);
        reg_rd(OFS_DBL_CFG_A, 8'hA5);
        check("dbl_en_o", 48'h0, 48'(dbl_en_o));
        reg_wr(OFS_DBL_CFG_B, 8'h01);
        reg_rd(OFS_DBL_CFG_B, 8'h01);
        check("dbl_en_o", 48'h1, 48'(dbl_en_o));
        reg_wr(OFS_DBL_CFG_B, 8'h00);
        reg_rd(OFS_DBL_CFG_B, 8'h00);
        check("dbl_en_o", 48'h0, 48'(dbl_en_o));
        reg_wr(OFS_DBL_CFG_B, 8'h01);
        reg_wr(16'h0011, 8'hFF);
        reg_rd(16'h0011, 8'h00);
        reg_wr(OFS_DBL_CFG_A, 8'h5A);
        reg_rd(OFS_DBL_CFG_A, 8'h5A);
        check("dbl_en_o", 48'h0, 48'(dbl_en_o));
        upd(0, 0, W0, W0);
        upd(1, 721, W0 + 10000, W0 + 721);
        upd(1, 721, W0 + 10000, W0 + 1442);
        upd(1, 721, W0 + 1000, W0 + 1000);
        upd(1, 721, W0, W0 + 279);
        upd(1, 279, W0, W0);
        upd(1, 0, W0 + 9, W0);
        upd(0, 721, W0 + 48'h10000, W0 + 48'h10000);
        @(negedge clk_sys_i);
        lf_valid_i = 0;
        lf_ftw_i = W0;
        held = ftw_o;
        repeat (2) @(negedge clk_sys_i);
        check("ftw_valid_o", 48'h0, 48'(ftw_valid_o));
        check("ftw_o", held, ftw_o);
        // Source one only with zero synth frequency, well under 50 MHz
        for (int i = 0; i < 4; i++) begin
            out_pd_i = i[0];
            cmos_src_i = i[1];
            @(negedge clk_sys_i);
            @(negedge clk_sys_i);
            check("out_pd_o", 48'(i[0]), 48'(out_pd_o));
            check("cmos_src_o", 48'(i[1]), 48'(cmos_src_o));
        end
        for (int h = 0; h < 16; h++) begin
            canc0_cfg_i = '{harm: 4'(h), phase_ofs: 9'h040, amp: 8'hFF, gain: 1'b0};
            canc1_cfg_i = '{harm: 4'(h), phase_ofs: 9'h140, amp: 8'h80, gain: 1'b1};
            repeat (12) @(negedge clk_sys_i);
            n = (h >= 2) ? canc(64, 255, 0) + canc(320, 128, 1) : 0;
            check("dac_last", 48'($unsigned(14'(n))), 48'(dac_last));
            check("dac_data_o", 48'($unsigned(14'(n))), 48'(dac_data_o));
        end
        canc1_cfg_i.harm = 4'h0;
        repeat (12) @(negedge clk_sys_i);
        check("dac_data_o", 48'(14'(canc(64, 255, 0))), 48'(dac_data_o));
        stall = 1;
        repeat (3) @(negedge clk_sys_i);
        n = taken;
        repeat (6) @(negedge clk_sys_i);
        check("taken", 48'(n), 48'(taken));
        check("dac_valid_o", 48'h1, 48'(dac_valid_o));
        stall = 0;
        repeat (4) @(negedge clk_sys_i);
        check("resumed", 48'h1, 48'(taken > n));
        // Half-circle main word: main sine stays zero, harmonic sets the step
        dds_ftw_i = 48'h8000_0000_0000;
        cmos_src_i = 0;
        canc0_cfg_i.harm = 4'h2;
        repeat (4) @(negedge clk_sys_i);
        n = $signed(dac_data_o);
        @(negedge clk_sys_i);
        held = 48'($unsigned(14'(2 * canc(64, 255, 0))));
        check("dac_even", held, 48'(14'(n) + dac_data_o));
        canc0_cfg_i.harm = 4'h3;
        repeat (4) @(negedge clk_sys_i);
        n = $signed(dac_data_o);
        @(negedge clk_sys_i);
        held = 48'($unsigned(14'(canc(64, 255, 0) + canc(320, 255, 0))));
        check("dac_odd", held, 48'(14'(n) + dac_data_o));
        final_report();
    end
endmodule
